// *** hdl/reset_start_pkg.sv ***
// Function
// - After clear release, nine cycles configure every port output type first.
// - Only after configuration does the program counter load zero and fetching start.
// - While chip clear is low, every port output is forced to open drain, except port zero in programming mode.
// - Chip clear low during hold standby keeps standby and restarts no configuration; port types still clear to open drain.
// - Port zero lines work as input or output, whole nibble or single line.
// - Each port zero line is selectable alone as halt release input.
// - In programming mode port zero lines serve as memory data lines.
// - In hold standby, raising the standby pin restarts the processor.
`default_nettype none
package reset_start_pkg;

    localparam int          CONFIG_CYCLES = 9;
    localparam logic [13:0] OPTION_BASE   = 14'h3FF0;
    localparam logic [13:0] START_PC      = 14'h0000;
    localparam logic [3:0]  CNT_ZERO      = 4'h0;
    localparam logic [3:0]  CNT_LAST      = 4'(CONFIG_CYCLES - 1);

    typedef enum logic [3:0] {
        ST_CLEAR  = 4'h1,
        ST_CONFIG = 4'h2,
        ST_RUN    = 4'h4,
        ST_HOLD   = 4'h8
    } seq_state_t;

    typedef struct packed {
        logic [3:0] out_val;
        logic [3:0] out_en;
    } port_drive_t;

endpackage
`default_nettype wire

// *** hdl/reset_start_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module reset_start_sequencer #(
    parameter int NUM_PORTS = 9
) (
    input  wire logic                        clk,
    input  wire logic                        srst,
    input  wire logic                        chip_clear_pin_n,
    input  wire logic                        standby_control_pin,
    input  wire logic                        hold_request,
    input  wire logic                        prog_mode,
    input  wire logic [7:0]                  option_data,
    output logic [13:0]                      option_addr,
    output logic [NUM_PORTS-1:0]             port_type_cmos,
    output logic                             cpu_run,
    output logic                             pc_load,
    output logic [13:0]                      pc_value,
    output logic                             in_hold,
    input  wire logic [3:0]                  p0_wr_data,
    input  wire logic [3:0]                  p0_wr_mask,
    input  wire logic                        p0_wr,
    input  wire logic [3:0]                  p0_dir_out,
    input  wire logic [3:0]                  halt_release_sel,
    input  wire logic [3:0]                  prog_data_out,
    input  wire logic                        prog_data_oe,
    input  wire logic [3:0]                  port_zero_in,
    output reset_start_pkg::port_drive_t     port_zero_drive,
    output logic [3:0]                       port_zero_read,
    output logic                             halt_release
);

    // =========================================================
    // Parameter check.
    if (NUM_PORTS < 1 || NUM_PORTS > reset_start_pkg::CONFIG_CYCLES)
    begin : g_bad_ports
        $error("NUM_PORTS must be 1 to the number of configuration cycles.");
    end

    // =========================================================
    // Sequencer state.
    reset_start_pkg::seq_state_t state_r;
    reset_start_pkg::seq_state_t state_nxt;
    logic [3:0]                  cnt_r;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            reset_start_pkg::ST_CLEAR:
                if (chip_clear_pin_n)
                    state_nxt = reset_start_pkg::ST_CONFIG;
            reset_start_pkg::ST_CONFIG:
                if (!chip_clear_pin_n)
                    state_nxt = reset_start_pkg::ST_CLEAR;
                else if (cnt_r == reset_start_pkg::CNT_LAST)
                    state_nxt = reset_start_pkg::ST_RUN;
            reset_start_pkg::ST_RUN:
                if (!chip_clear_pin_n)
                    state_nxt = reset_start_pkg::ST_CLEAR;
                else if (hold_request && !standby_control_pin)
                    state_nxt = reset_start_pkg::ST_HOLD;
            reset_start_pkg::ST_HOLD:
                if (standby_control_pin)
                    state_nxt = reset_start_pkg::ST_RUN;
            default:
                state_nxt = reset_start_pkg::ST_CLEAR;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_r <= reset_start_pkg::ST_CLEAR;
        else
            state_r <= state_nxt;
    end

    // =========================================================
    // Cycle counter.
    always_ff @(posedge clk)
    begin
        if (srst || state_r != reset_start_pkg::ST_CONFIG || !chip_clear_pin_n)
            cnt_r <= reset_start_pkg::CNT_ZERO;
        else if (cnt_r != reset_start_pkg::CNT_LAST)
            cnt_r <= cnt_r + 4'h1;
    end

    // =========================================================
    // Option load and program start.
    logic [3:0] cfg_index;

    always_comb
    begin
        cfg_index = reset_start_pkg::CNT_ZERO;
        if (state_r == reset_start_pkg::ST_CONFIG && state_nxt == reset_start_pkg::ST_CONFIG)
            cfg_index = cnt_r + 4'h1;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            option_addr <= reset_start_pkg::OPTION_BASE;
        else
            option_addr <= reset_start_pkg::OPTION_BASE + {10'h000, cfg_index};
    end

    always_ff @(posedge clk)
    begin
        if (srst || !chip_clear_pin_n || state_nxt == reset_start_pkg::ST_CLEAR)
            port_type_cmos <= '0;
        else if (state_r == reset_start_pkg::ST_CONFIG && int'(cnt_r) < NUM_PORTS)
            port_type_cmos[cnt_r] <= option_data[0];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cpu_run  <= 1'b0;
            pc_load  <= 1'b0;
            pc_value <= reset_start_pkg::START_PC;
            in_hold  <= 1'b0;
        end
        else
        begin
            cpu_run  <= state_nxt == reset_start_pkg::ST_RUN;
            pc_load  <= state_r == reset_start_pkg::ST_CONFIG
                        && state_nxt == reset_start_pkg::ST_RUN;
            pc_value <= reset_start_pkg::START_PC;
            in_hold  <= state_nxt == reset_start_pkg::ST_HOLD;
        end
    end

    // =========================================================
    // Port zero.
    logic [3:0] p0_latch_r;

    always_ff @(posedge clk)
    begin
        if (srst)
            p0_latch_r <= 4'hF;
        else if (p0_wr)
            p0_latch_r <= (p0_latch_r & ~p0_wr_mask) | (p0_wr_data & p0_wr_mask);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            port_zero_drive <= '0;
            port_zero_read  <= 4'h0;
            halt_release    <= 1'b0;
        end
        else
        begin
            port_zero_read <= port_zero_in;
            halt_release   <= |(halt_release_sel & ~port_zero_in);
            if (prog_mode)
            begin
                port_zero_drive.out_val <= prog_data_out;
                port_zero_drive.out_en  <= {4{prog_data_oe}};
            end
            else if (!chip_clear_pin_n || state_nxt == reset_start_pkg::ST_CLEAR
                     || !port_type_cmos[0])
            begin
                port_zero_drive.out_val <= 4'h0;
                port_zero_drive.out_en  <= p0_dir_out & ~p0_latch_r;
            end
            else
            begin
                port_zero_drive.out_val <= p0_latch_r;
                port_zero_drive.out_en  <= p0_dir_out;
            end
        end
    end

    // =========================================================
    // Checks and start, hold and re-clear coverage.
    logic [3:0] clr_run_r;

    always_ff @(posedge clk)
    begin
        if (srst || !chip_clear_pin_n)
            clr_run_r <= reset_start_pkg::CNT_ZERO;
        else if (!(&clr_run_r))
            clr_run_r <= clr_run_r + 4'h1;
    end

    config_len_a: assert property (@(posedge clk) disable iff (srst)
        $rose(pc_load) |-> clr_run_r == reset_start_pkg::CNT_LAST + 4'h2)
        else $error("Program start came before nine configuration cycles.");
    pc_zero_a: assert property (@(posedge clk) disable iff (srst)
        pc_load |-> pc_value == 14'h0000 && cpu_run)
        else $error("Program counter not zero at start.");
    od_clear_a: assert property (@(posedge clk) disable iff (srst)
        !chip_clear_pin_n |=> port_type_cmos == '0)
        else $error("Port left push-pull during clear.");
    hold_keep_a: assert property (@(posedge clk) disable iff (srst)
        in_hold && !standby_control_pin |=> in_hold)
        else $error("Hold standby left without standby pin.");
    hold_wake_a: assert property (@(posedge clk) disable iff (srst)
        in_hold && standby_control_pin |=> cpu_run)
        else $error("Processor not restarted from hold.");
    cnt_clear_a: assert property (@(posedge clk) disable iff (srst)
        !chip_clear_pin_n |=> cnt_r == 4'h0)
        else $error("Counter not restarted by clear.");
    prog_data_a: assert property (@(posedge clk) disable iff (srst)
        prog_mode |=> port_zero_drive.out_val == $past(prog_data_out))
        else $error("Port zero not carrying memory data.");
    halt_rel_a: assert property (@(posedge clk) disable iff (srst)
        halt_release_sel == 4'h0 |=> !halt_release)
        else $error("Halt release from unselected line.");
    start_c: cover property (@(posedge clk) disable iff (srst) $rose(pc_load));
    hold_c: cover property (@(posedge clk) disable iff (srst) $fell(in_hold));
    reclear_c: cover property (@(posedge clk) disable iff (srst)
        state_r == reset_start_pkg::ST_CONFIG && !chip_clear_pin_n);

    // =========================================================
    // Coverage.
    prog_c: cover property (@(posedge clk) disable iff (srst) prog_mode && prog_data_oe);
    halt_c: cover property (@(posedge clk) disable iff (srst) $rose(halt_release));

endmodule
`default_nettype wire

// *** test/option_rom_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Option area model of program memory.
module option_rom_model (
    input  wire logic [13:0]  option_addr,
    input  wire logic [127:0] option_image,
    output logic [7:0]        option_data
);
    // ============================================================
    // Option bytes sit in the top sixteen places; all else reads zero.
    always_comb
    begin
        if (option_addr[13:4] == 10'h3FF)
            option_data = option_image[{option_addr[3:0], 3'h0} +: 8];
        else
            option_data = 8'h00;
    end
endmodule
`default_nettype wire

// *** test/reset_start_sequencer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module reset_start_sequencer_tb;
    logic                            clk = 1'b0, srst = 1'b1, clr_n = 1'b0, stby = 1'b1;
    logic                            hold_req = 1'b0, live = 1'b0, pc_load, cpu_run, in_hold;
    logic                            hrel, wr = 1'b0;
    logic [127:0]                    image;
    logic [13:0]                     opt_addr, pc_value;
    logic [7:0]                      opt_data;
    logic [8:0]                      ptype;
    logic [3:0]                      pin = 4'h0, sel = 4'h0, wd = 4'h0, wm = 4'h0;
    logic [3:0]                      dir = 4'h0, rd;
    reset_start_pkg::port_drive_t    drv;
    int                              n_mismatch = 0, check_count = 0, seed = 32'hD31F141C, i;
    logic                            prog = 1'b0, poe = 1'b0, mt0 = 1'b0, mpl = 1'b0;
    logic [2:0]                      mseq = 3'h0;
    logic [3:0]                      pdo = 4'h0, latch_m = 4'hF;
    reset_start_pkg::port_drive_t    drv_m = '0;
    int                              ms = 0, mc = 0;
    // ============================================================
    // Clock, far side and design.
    always #20 clk = ~clk;
    option_rom_model u_option_rom_model (.option_addr(opt_addr), .option_image(image),
        .option_data(opt_data));
    reset_start_sequencer #(.NUM_PORTS(9)) u_reset_start_sequencer (.clk(clk), .srst(srst),
        .chip_clear_pin_n(clr_n), .standby_control_pin(stby), .hold_request(hold_req),
        .prog_mode(prog), .option_data(opt_data), .option_addr(opt_addr),
        .port_type_cmos(ptype), .cpu_run(cpu_run), .pc_load(pc_load), .pc_value(pc_value),
        .in_hold(in_hold), .p0_wr_data(wd), .p0_wr_mask(wm), .p0_wr(wr), .p0_dir_out(dir),
        .halt_release_sel(sel), .prog_data_out(pdo), .prog_data_oe(poe),
        .port_zero_in(pin), .port_zero_drive(drv), .port_zero_read(rd),
        .halt_release(hrel));
    // ============================================================
    // Behavioural model of the start sequence and port zero, stepped on each rising edge.
    always @(posedge clk)
    begin
        if (prog)
            drv_m = {pdo, {4{poe}}};
        else if (!clr_n || !mt0)
            drv_m = {4'h0, dir & ~latch_m};
        else
            drv_m = {latch_m, dir};
        if (wr)
            latch_m = (latch_m & ~wm) | (wd & wm);
        mpl = 1'b0;
        if (ms == 0 && clr_n)
        begin
            ms = 1;
            mc = 0;
        end
        else if (ms == 1 && clr_n)
        begin
            if (mc == 0)
                mt0 = image[0];
            mpl = (mc == reset_start_pkg::CONFIG_CYCLES - 1);
            ms = mpl ? 2 : 1;
            mc++;
        end
        else if ((ms == 1 || ms == 2) && !clr_n)
            ms = 0;
        else if (ms == 2 && hold_req && !stby)
            ms = 3;
        else if (ms == 3 && stby)
            ms = 2;
        if (!clr_n)
            mt0 = 1'b0;
        if (srst)
        begin
            ms = 0;
            mt0 = 1'b0;
            mpl = 1'b0;
            latch_m = 4'hF;
            drv_m = '0;
        end
        mseq = {ms == 2, ms == 3, mpl};
    end
    // ============================================================
    // Checks and run control.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [8:0] exp_type();
        logic [8:0] e;
        for (int k = 0; k < 9; k++)
            e[k] = image[8*k];
        return e;
    endfunction
    task automatic start_run();
        clr_n = 1'b1;
        repeat (9) @(posedge clk);
        @(negedge clk);
        chk(16'({pc_load, cpu_run}), 16'h0000, "early start");
        @(negedge clk);
        chk({pc_load, cpu_run, pc_value}, 16'hC000, "start at zero");
        chk(16'(ptype), 16'(exp_type()), "port type");
        @(negedge clk);
        chk(16'(pc_load), 16'h0000, "start pulse");
    endtask
    task automatic wait_hold(input logic v);
        for (int n = 0; n < 20 && in_hold !== v; n++)
            @(negedge clk);
    endtask
    // ============================================================
    // Random port zero traffic with read back and halt release checks.
    always @(negedge clk)
    begin
        if (live)
        begin
            chk(16'(rd), 16'(pin), "read back");
            chk(16'(hrel), 16'(|(sel & ~pin)), "halt release");
            chk(16'(drv), 16'(drv_m), "port zero drive");
            chk(16'({cpu_run, in_hold, pc_load}), 16'(mseq), "sequence state");
        end
        pin = 4'($random(seed));
        sel = 4'($random(seed));
        wd = 4'($random(seed));
        wm = 4'($random(seed));
        dir = 4'($random(seed));
        wr = 1'($random(seed));
        prog = 1'($random(seed));
        pdo = 4'($random(seed));
        poe = 1'($random(seed));
    end
    initial
    begin
        #(40 * 4000);
        n_mismatch++;
        stop_test();
    end
    initial
    begin
        for (i = 0; i < 16; i++)
            image[8*i +: 8] = 8'($random(seed));
        repeat (8) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        live = 1'b1;
        start_run();
        clr_n = 1'b0;
        @(negedge clk);
        chk(16'({ptype, cpu_run}), 16'h0000, "open drain in clear");
        clr_n = 1'b1;
        repeat (4) @(negedge clk);
        clr_n = 1'b0;
        @(negedge clk);
        start_run();
        stby = 1'b0;
        hold_req = 1'b1;
        @(negedge clk);
        hold_req = 1'b0;
        wait_hold(1'b1);
        clr_n = 1'b0;
        repeat (5) @(negedge clk);
        chk(16'({ptype, in_hold, cpu_run}), 16'h0002, "clear in hold");
        clr_n = 1'b1;
        repeat (12) @(negedge clk);
        chk(16'({in_hold, pc_load}), 16'h0002, "no restart in hold");
        stby = 1'b1;
        wait_hold(1'b0);
        chk(16'({in_hold, cpu_run}), 16'h0001, "wake from hold");
        clr_n = 1'b0;
        repeat (3) @(negedge clk);
        start_run();
        stop_test();
    end
endmodule
`default_nettype wire
